// ===== isp_pkg.sv
// constants for the serial in-system programming slave
package isp_pkg;
   // instruction opcodes and fixed bytes
   localparam logic [7:0] PROG_ENABLE_B1 = 8'hAC;
   localparam logic [7:0] PROG_ENABLE_B2 = 8'h53;
   localparam logic [7:0] CHIP_ERASE_B1 = 8'hAC;
   localparam logic [2:0] CHIP_ERASE_B2_TOP = 3'h4;
   localparam logic [7:0] READ_FLASH_B1 = 8'h20;
   localparam logic [7:0] LOAD_PAGE_B1 = 8'h40;
   localparam logic [7:0] HIGH_SEL_MASK = 8'hF7;
   localparam int HIGH_SEL_BIT = 3;
   localparam logic [7:0] WRITE_PAGE_B1 = 8'h4C;
   localparam logic [7:0] READ_EE_B1 = 8'hA0;
   localparam logic [7:0] WRITE_EE_B1 = 8'hC0;
   // erased contents and idle read value
   localparam logic [7:0] ERASED_BYTE = 8'hFF;
   localparam logic [15:0] ERASED_WORD = 16'hFFFF;
   localparam logic [7:0] IDLE_READ_BYTE = 8'h00;
   // memory geometry
   localparam int PAGE_WORD_AW = 6;
   localparam int PAGE_SEL_W = 8;
   localparam int EE_ADDR_W = 10;
   // serial framing: bit counts at which bytes complete
   localparam int BIT_CNT_W = 5;
   localparam logic [4:0] ECHO_LAST_BIT = 5'h0F;
   localparam logic [4:0] HDR_LAST_BIT = 5'h17;
   localparam logic [4:0] CMD_LAST_BIT = 5'h1F;
   localparam logic [1:0] ECHO_BYTE_IDX = 2'h2;
   localparam logic [1:0] DATA_BYTE_IDX = 2'h3;
   // self-timed write durations
   localparam real CLK_PERIOD_NS = 40.0;
   localparam real FLASH_PAGE_WAIT_DELAY_MS = 4.5;
   localparam real EEPROM_BYTE_WAIT_DELAY_MS = 9.0;
   localparam real CHIP_ERASE_WAIT_DELAY_MS = 9.0;
   localparam int FLASH_PAGE_WAIT_CYC = int'($floor(FLASH_PAGE_WAIT_DELAY_MS * 1.0e6 / CLK_PERIOD_NS));
   localparam int EEPROM_BYTE_WAIT_CYC = int'($floor(EEPROM_BYTE_WAIT_DELAY_MS * 1.0e6 / CLK_PERIOD_NS));
   localparam int CHIP_ERASE_WAIT_CYC = int'($floor(CHIP_ERASE_WAIT_DELAY_MS * 1.0e6 / CLK_PERIOD_NS));
   // controller state and running operation
   typedef enum logic {ST_IDLE, ST_BUSY} nvm_state_t;
   typedef enum logic [1:0] {OP_NONE, OP_PAGE, OP_EE, OP_ERASE} nvm_op_t;
endpackage : isp_pkg

// ===== isp_slave.sv
// serial programming slave: SCK-side shifter plus REF_CLK-side flash/EEPROM controller
// Summary of operation
// - programming accepted only while reset pin low
// - enable instruction required before program or erase
// - EEPROM byte write erases location itself
// - chip erase fills flash and EEPROM with ones
// - sample MOSI rising, shift MISO falling
// - echo second enable byte during third byte
// - page buffer loaded bytewise by word index
// - write-page commits buffer to selected page
// - EEPROM written one byte per instruction
// - read returns addressed memory on MISO once enabled, zero before
// - releasing reset ends programming mode
// - read inside busy page returns ones
// - enable is AC 53 then two free bytes
// - write-page opcode then page address fields
`timescale 1ns/1ps
module isp_slave #(
   parameter int FLASH_WAIT_CYC = isp_pkg::FLASH_PAGE_WAIT_CYC,
   parameter int EE_WAIT_CYC = isp_pkg::EEPROM_BYTE_WAIT_CYC,
   parameter int ERASE_WAIT_CYC = isp_pkg::CHIP_ERASE_WAIT_CYC
) (
   input wire logic REF_CLK,
   input wire logic SRST,
   input wire logic SCK,
   input wire logic MOSI,
   input wire logic DEV_RESET_N,
   output logic MISO,
   output logic PROG_ENABLED,
   output logic NVM_BUSY
);
   import isp_pkg::*;

   localparam int FLASH_AW = PAGE_WORD_AW + PAGE_SEL_W;

   // ---------------- SCK domain ----------------
   logic [BIT_CNT_W-1:0] bit_cnt_ff;
   logic [30:0] shift_ff;
   logic [7:0] echo_ff;
   logic [23:0] hdr_ff;
   logic [31:0] cmd_ff;
   logic hdr_tgl_ff;
   logic cmd_tgl_ff;
   logic miso_ff;
   logic [7:0] rd_data_ff;

   wire [31:0] shift_full = {shift_ff, MOSI};
   wire [BIT_CNT_W-1:0] nxt_bit_cnt = bit_cnt_ff + BIT_CNT_W'(1);

   // bit counter and input shifter; only the reset pin realigns the framing
   always_ff @(posedge SCK or posedge DEV_RESET_N) begin
      if (DEV_RESET_N) begin
         bit_cnt_ff <= '0;
         shift_ff <= '0;
      end else begin
         bit_cnt_ff <= nxt_bit_cnt;
         shift_ff <= shift_full[30:0];
      end
   end

   // capture second byte for echo, header after byte three, whole word after byte four
   always_ff @(posedge SCK or posedge DEV_RESET_N) begin
      if (DEV_RESET_N) begin
         echo_ff <= 8'h00;
         hdr_ff <= 24'h000000;
         cmd_ff <= 32'h00000000;
      end else begin
         if (bit_cnt_ff == ECHO_LAST_BIT) echo_ff <= shift_full[7:0];
         if (bit_cnt_ff == HDR_LAST_BIT) hdr_ff <= shift_full[23:0];
         if (bit_cnt_ff == CMD_LAST_BIT) cmd_ff <= shift_full;
      end
   end

   // toggles announce a stable header / command; the words themselves hold until the next frame
   always_ff @(posedge SCK or posedge DEV_RESET_N) begin
      if (DEV_RESET_N) begin
         hdr_tgl_ff <= 1'b0;
         cmd_tgl_ff <= 1'b0;
      end else begin
         if (bit_cnt_ff == HDR_LAST_BIT) hdr_tgl_ff <= ~hdr_tgl_ff;
         if (bit_cnt_ff == CMD_LAST_BIT) cmd_tgl_ff <= ~cmd_tgl_ff;
      end
   end

   // output selection: echo during byte three, read data during byte four, zero otherwise
   wire [1:0] out_byte_idx = bit_cnt_ff[4:3];
   wire [2:0] out_bit_sel = 3'h7 - bit_cnt_ff[2:0];
   wire echo_bit = echo_ff[out_bit_sel];
   wire data_bit = rd_data_ff[out_bit_sel];
   wire nxt_miso = (out_byte_idx == ECHO_BYTE_IDX) ? echo_bit :
                   (out_byte_idx == DATA_BYTE_IDX) ? data_bit : 1'b0;

   // MISO changes on the falling edge so the programmer samples it on the rising one
   always_ff @(negedge SCK or posedge DEV_RESET_N) begin
      if (DEV_RESET_N) miso_ff <= 1'b0;
      else miso_ff <= nxt_miso;
   end

   assign MISO = miso_ff;

   // ---------------- REF_CLK domain ----------------
   logic rst_s1_ff, rst_s2_ff;
   logic hdr_s1_ff, hdr_s2_ff, hdr_seen_ff;
   logic cmd_s1_ff, cmd_s2_ff, cmd_seen_ff;
   logic enabled_ff;
   logic busy_ff;
   nvm_state_t st_ff, nxt_st;
   nvm_op_t op_ff;
   logic [31:0] timer_ff;
   logic [FLASH_AW-1:0] walk_ff;
   logic walk_done_ff;
   logic [PAGE_SEL_W-1:0] page_ff;
   logic [EE_ADDR_W-1:0] ee_addr_ff;

   logic [15:0] flash_mem [2**FLASH_AW];
   logic [7:0] ee_mem [2**EE_ADDR_W];
   logic [15:0] pbuf_mem [2**PAGE_WORD_AW];

   // two-stage synchronisers; only the second stage feeds logic
   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         rst_s1_ff <= 1'b1;
         rst_s2_ff <= 1'b1;
      end else begin
         rst_s1_ff <= DEV_RESET_N;
         rst_s2_ff <= rst_s1_ff;
      end
   end

   // toggle crossings for header-ready and command-ready events
   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         hdr_s1_ff <= 1'b0;
         hdr_s2_ff <= 1'b0;
         hdr_seen_ff <= 1'b0;
         cmd_s1_ff <= 1'b0;
         cmd_s2_ff <= 1'b0;
         cmd_seen_ff <= 1'b0;
      end else begin
         hdr_s1_ff <= hdr_tgl_ff;
         hdr_s2_ff <= hdr_s1_ff;
         hdr_seen_ff <= hdr_s2_ff;
         cmd_s1_ff <= cmd_tgl_ff;
         cmd_s2_ff <= cmd_s1_ff;
         cmd_seen_ff <= cmd_s2_ff;
      end
   end

   // events are dropped outside programming mode; the seen copies still track so
   // the toggles clearing under reset do not fire later
   wire prog_mode = ~rst_s2_ff;
   wire hdr_evt = (hdr_s2_ff ^ hdr_seen_ff) & prog_mode;
   wire cmd_evt = (cmd_s2_ff ^ cmd_seen_ff) & prog_mode;

   // command decode from the stable command word
   wire [7:0] c_b1 = cmd_ff[31:24];
   wire [7:0] c_b2 = cmd_ff[23:16];
   wire [7:0] c_b3 = cmd_ff[15:8];
   wire [7:0] c_b4 = cmd_ff[7:0];
   wire is_enable = (c_b1 == PROG_ENABLE_B1) && (c_b2 == PROG_ENABLE_B2);
   wire is_erase = (c_b1 == CHIP_ERASE_B1) && (c_b2[7:5] == CHIP_ERASE_B2_TOP);
   wire is_load = (c_b1 & HIGH_SEL_MASK) == LOAD_PAGE_B1;
   wire is_wpage = c_b1 == WRITE_PAGE_B1;
   wire is_wee = c_b1 == WRITE_EE_B1;
   wire c_high = c_b1[HIGH_SEL_BIT];
   wire [PAGE_WORD_AW-1:0] c_word = c_b3[PAGE_WORD_AW-1:0];
   wire [PAGE_SEL_W-1:0] c_page = {c_b2[5:0], c_b3[7:6]};
   wire [EE_ADDR_W-1:0] c_ee_addr = {c_b2[1:0], c_b3};

   // writes need an enabled, idle device; anything else during a write is ignored
   wire accept = cmd_evt && enabled_ff && (st_ff == ST_IDLE);
   wire start_page = accept && is_wpage;
   wire start_ee = accept && is_wee;
   wire start_erase = accept && is_erase && !is_enable;
   wire load_evt = accept && is_load;
   wire start_any = start_page | start_ee | start_erase;

   // programming enable: set by the enable word, lost when the reset pin goes high
   always_ff @(posedge REF_CLK) begin
      if (SRST) enabled_ff <= 1'b0;
      else if (!prog_mode) enabled_ff <= 1'b0;
      else if (cmd_evt && is_enable) enabled_ff <= 1'b1;
   end

   // self-timed duration of the running operation
   wire [31:0] wait_limit = (op_ff == OP_PAGE) ? 32'(FLASH_WAIT_CYC) :
                            (op_ff == OP_EE) ? 32'(EE_WAIT_CYC) : 32'(ERASE_WAIT_CYC);
   wire timer_done = (timer_ff + 32'h00000001) >= wait_limit;
   wire walk_last = (op_ff == OP_PAGE) ? (&walk_ff[PAGE_WORD_AW-1:0]) : (&walk_ff);
   wire op_done = timer_done && walk_done_ff;

   // idle/busy controller; a write ends only once its array walk and its time are both done
   always_comb begin
      nxt_st = st_ff;
      case (st_ff)
         ST_IDLE: begin
            if (start_any) nxt_st = ST_BUSY;
         end
         ST_BUSY: begin
            if (op_done) nxt_st = ST_IDLE;
         end
         default: nxt_st = ST_IDLE;
      endcase
   end

   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         st_ff <= ST_IDLE;
         busy_ff <= 1'b0;
      end else begin
         st_ff <= nxt_st;
         busy_ff <= nxt_st == ST_BUSY;
      end
   end

   // operation bookkeeping latched at start
   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         op_ff <= OP_NONE;
         page_ff <= '0;
         ee_addr_ff <= '0;
      end else if (start_any) begin
         op_ff <= start_page ? OP_PAGE : (start_ee ? OP_EE : OP_ERASE);
         page_ff <= c_page;
         ee_addr_ff <= c_ee_addr;
      end
   end

   // timer and walk counter; an EEPROM byte needs no walk, so it starts done
   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         timer_ff <= 32'h00000000;
         walk_ff <= '0;
         walk_done_ff <= 1'b0;
      end else if (start_any) begin
         timer_ff <= 32'h00000000;
         walk_ff <= '0;
         walk_done_ff <= start_ee;
      end else if (st_ff == ST_BUSY) begin
         timer_ff <= timer_ff + 32'h00000001;
         if (!walk_done_ff) walk_ff <= walk_ff + FLASH_AW'(1);
         if (!walk_done_ff && walk_last) walk_done_ff <= 1'b1;
      end
   end

   // walk position shared by the page buffer and the arrays
   wire walking = (st_ff == ST_BUSY) && !walk_done_ff;
   wire [PAGE_WORD_AW-1:0] walk_word = walk_ff[PAGE_WORD_AW-1:0];

   // page buffer: one byte lane per load; a commit or erase walk refills it with ones,
   // so words the programmer skips end up erased instead of carrying stale data
   always_ff @(posedge REF_CLK) begin
      if (load_evt && c_high) pbuf_mem[c_word][15:8] <= c_b4;
      if (load_evt && !c_high) pbuf_mem[c_word][7:0] <= c_b4;
      if (walking && op_ff != OP_EE) pbuf_mem[walk_word] <= ERASED_WORD;
   end

   // array writes: page commit and erase walk one word per cycle, EEPROM byte at once
   always_ff @(posedge REF_CLK) begin
      if (walking && op_ff == OP_PAGE) flash_mem[{page_ff, walk_word}] <= pbuf_mem[walk_word];
      if (walking && op_ff == OP_ERASE) flash_mem[walk_ff] <= ERASED_WORD;
   end

   // the EEPROM write replaces the old byte outright, so no separate erase is needed
   always_ff @(posedge REF_CLK) begin
      if (start_ee) ee_mem[c_ee_addr] <= c_b4;
      else if (walking && op_ff == OP_ERASE) ee_mem[walk_ff[EE_ADDR_W-1:0]] <= ERASED_BYTE;
   end

   // read decode from the header, ready before byte four starts shifting out
   wire [7:0] h_b1 = hdr_ff[23:16];
   wire [7:0] h_b2 = hdr_ff[15:8];
   wire [7:0] h_b3 = hdr_ff[7:0];
   wire h_rd_flash = (h_b1 & HIGH_SEL_MASK) == READ_FLASH_B1;
   wire h_rd_ee = h_b1 == READ_EE_B1;
   wire [FLASH_AW-1:0] h_flash_addr = {h_b2[5:0], h_b3};
   wire [EE_ADDR_W-1:0] h_ee_addr = {h_b2[1:0], h_b3};
   wire [15:0] h_word = flash_mem[h_flash_addr];
   wire [7:0] h_flash_byte = h_b1[HIGH_SEL_BIT] ? h_word[15:8] : h_word[7:0];
   wire busy_erase = (st_ff == ST_BUSY) && (op_ff == OP_ERASE);
   wire flash_poll = ((st_ff == ST_BUSY) && (op_ff == OP_PAGE) &&
                      (h_flash_addr[FLASH_AW-1:PAGE_WORD_AW] == page_ff)) || busy_erase;
   wire ee_poll = ((st_ff == ST_BUSY) && (op_ff == OP_EE) && (h_ee_addr == ee_addr_ff)) || busy_erase;
   wire [7:0] flash_rd = flash_poll ? ERASED_BYTE : h_flash_byte;
   wire [7:0] ee_rd = ee_poll ? ERASED_BYTE : ee_mem[h_ee_addr];
   wire [7:0] nxt_rd_data = !enabled_ff ? IDLE_READ_BYTE :
                            h_rd_flash ? flash_rd : (h_rd_ee ? ee_rd : IDLE_READ_BYTE);

   // read data is only changed at a header event, so the SCK side sees a settled word
   always_ff @(posedge REF_CLK) begin
      if (SRST) rd_data_ff <= IDLE_READ_BYTE;
      else if (hdr_evt) rd_data_ff <= nxt_rd_data;
   end

   assign PROG_ENABLED = enabled_ff;
   assign NVM_BUSY = busy_ff;

   // ---------------- checks ----------------
   a_enable_needs_mode: assert property (
      @(posedge REF_CLK) disable iff (SRST) $rose(enabled_ff) |-> $past(prog_mode) && $past(cmd_evt))
      else $error("enable set outside programming mode");

   a_exit_clears_enable: assert property (
      @(posedge REF_CLK) disable iff (SRST) !prog_mode |=> !enabled_ff)
      else $error("enable survived reset release");

   a_no_op_unenabled: assert property (
      @(posedge REF_CLK) disable iff (SRST) (st_ff == ST_IDLE && !enabled_ff) |=> st_ff == ST_IDLE)
      else $error("write started without enable");

   a_page_commit_start: assert property (
      @(posedge REF_CLK) disable iff (SRST) start_page |=> busy_ff && op_ff == OP_PAGE && page_ff == $past(c_page))
      else $error("page write did not start on the selected page");

   a_load_byte_lane: assert property (
      @(posedge REF_CLK) disable iff (SRST) (load_evt && !c_high) |=> pbuf_mem[$past(c_word)][7:0] == $past(c_b4))
      else $error("low byte not loaded into page buffer");

   a_ee_byte_written: assert property (
      @(posedge REF_CLK) disable iff (SRST) start_ee |=> ee_mem[$past(c_ee_addr)] == $past(c_b4))
      else $error("eeprom byte not written");

   a_busy_ignores_cmd: assert property (
      @(posedge REF_CLK) disable iff (SRST) (st_ff == ST_BUSY && cmd_evt) |=> $stable(op_ff) && $stable(page_ff))
      else $error("command changed a running write");

   a_poll_reads_ones: assert property (
      @(posedge REF_CLK) disable iff (SRST) (hdr_evt && enabled_ff && h_rd_flash && flash_poll) |=> rd_data_ff == 8'hFF)
      else $error("busy page read did not return ones");

   a_erase_walks_all: assert property (
      @(posedge REF_CLK) disable iff (SRST) ($fell(busy_ff) && op_ff == OP_ERASE) |-> walk_done_ff && walk_ff == '0)
      else $error("erase ended before every location was cleared");

   a_echo_capture: assert property (
      @(posedge SCK) disable iff (DEV_RESET_N) (bit_cnt_ff == ECHO_LAST_BIT) |=> echo_ff == $past(shift_full[7:0]))
      else $error("second byte not held for echo");

endmodule : isp_slave

// ===== isp_programmer.sv
// behavioural in-system programmer that drives the serial link of the slave
`timescale 1ns/1ps
module isp_programmer #(
   parameter int SCK_LOW_NS = 160,
   parameter int SCK_HIGH_NS = 240,
   parameter int RST_PULSE_NS = 160,
   parameter int POWERUP_WAIT_NS = 2000
) (
   output logic SCK,
   output logic MOSI,
   output logic DEV_RESET_N,
   input wire logic MISO
);
   logic link_ready;

   // power-up with reset pin and clock low; the wait is shortened to keep the run brief
   initial begin
      SCK = 1'b0;
      MOSI = 1'b0;
      DEV_RESET_N = 1'b0;
      link_ready = 1'b0;
      // the link logic has no power-on clear, so pulse the reset pin once with the clock parked low
      #(RST_PULSE_NS);
      DEV_RESET_N = 1'b1;
      #(RST_PULSE_NS);
      DEV_RESET_N = 1'b0;
      #(POWERUP_WAIT_NS);
      link_ready = 1'b1;
   end

   // data changes while the clock is low; both ends sample on the rising edge
   task automatic shift_bit(input logic tx, output logic rx);
      MOSI = tx;
      #(SCK_LOW_NS);
      rx = MISO;
      SCK = 1'b1;
      #(SCK_HIGH_NS);
      SCK = 1'b0;
   endtask : shift_bit

   // always four whole bytes, msb first; the clock then stands still
   task automatic frame(input logic [31:0] tx, output logic [31:0] rx);
      for (int i = 31; i >= 0; i--) begin
         shift_bit(tx[i], rx[i]);
      end
      MOSI = ~MOSI; // no pull on this line, so it must not hold the last bit
      #(SCK_LOW_NS); // keeps the next frame's first data change out of this time step
   endtask : frame

   // a stray bit, used to knock the framing out of step
   task automatic one_bit(input logic tx);
      logic dummy;
      shift_bit(tx, dummy);
   endtask : one_bit

   // reset pin level with the clock parked low, held for the given time
   task automatic set_reset_pin(input logic level, input int hold_ns);
      SCK = 1'b0;
      DEV_RESET_N = level;
      #(hold_ns);
   endtask : set_reset_pin
endmodule : isp_programmer

// ===== tb_top.sv
// self-checking bench for the serial programming slave
`timescale 1ns/1ps
module tb_top;
   import isp_pkg::*;
   // flash and EEPROM busy times long enough that a polling read lands inside them; the erase walk outlasts its 200-cycle time
   localparam int FLASH_CYC = 800;
   localparam int EE_CYC = 1000;
   localparam int ERASE_CYC = 200;
   logic ref_clk;
   logic srst;
   logic sck;
   logic mosi;
   logic dev_reset_n;
   logic miso;
   logic prog_enabled;
   logic nvm_busy;
   logic [7:0] echo;
   logic [7:0] rd;
   int n_fail;
   int total_checks;

   isp_slave #(.FLASH_WAIT_CYC(FLASH_CYC), .EE_WAIT_CYC(EE_CYC), .ERASE_WAIT_CYC(ERASE_CYC)) uut (
      .REF_CLK(ref_clk),
      .SRST(srst),
      .SCK(sck),
      .MOSI(mosi),
      .DEV_RESET_N(dev_reset_n),
      .MISO(miso),
      .PROG_ENABLED(prog_enabled),
      .NVM_BUSY(nvm_busy)
   );

   isp_programmer prog (.SCK(sck), .MOSI(mosi), .DEV_RESET_N(dev_reset_n), .MISO(miso));

   // cpu clock, 40 ns
   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end

   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic settle(input int n);
      repeat (n) @(posedge ref_clk);
      #2;
   endtask : settle

   // one instruction; keeps the echo byte and the answer byte
   task automatic cmd(input logic [7:0] b1, b2, b3, b4);
      logic [31:0] rx;
      prog.frame({b1, b2, b3, b4}, rx);
      echo = rx[15:8];
      rd = rx[7:0];
   endtask : cmd

   task automatic rd_check(input string what, input logic [7:0] b1, b2, b3, exp);
      cmd(b1, b2, b3, 8'h00);
      check(what, rd, exp);
   endtask : rd_check

   task automatic flags(input string what, input logic en, input logic bsy);
      settle(4);
      check({what, "_en"}, {7'h00, prog_enabled}, {7'h00, en});
      check({what, "_busy"}, {7'h00, nvm_busy}, {7'h00, bsy});
   endtask : flags

   // bounded wait on the busy flag; nothing is sent on the link meanwhile
   task automatic wait_idle();
      int n;
      n = 0;
      while (nvm_busy !== 1'b0 && n < 20000) begin
         settle(1);
         n++;
      end
      check("busy_done", {7'h00, nvm_busy}, 8'h00);
   endtask : wait_idle

   task automatic s_not_enabled();
      cmd(8'hC0, 8'h03, 8'hA7, 8'h5A);
      flags("pre_write", 1'b0, 1'b0);
      rd_check("pre_read", 8'hA0, 8'h03, 8'hA7, 8'h00);
   endtask : s_not_enabled

   task automatic s_enable();
      cmd(PROG_ENABLE_B1, PROG_ENABLE_B2, 8'h00, 8'h00);
      check("echo", echo, 8'h53);
      flags("enable", 1'b1, 1'b0);
   endtask : s_enable

   task automatic s_erase();
      cmd(8'hAC, 8'h80, 8'h00, 8'h00);
      flags("erase", 1'b1, 1'b1);
      rd_check("erase_poll", 8'h20, 8'h00, 8'h00, 8'hFF);
      wait_idle();
      rd_check("erase_fl_lo", 8'h20, 8'h3F, 8'hFF, 8'hFF);
      rd_check("erase_fl_hi", 8'h28, 8'h00, 8'h00, 8'hFF);
      rd_check("erase_ee", 8'hA0, 8'h03, 8'hFF, 8'hFF);
   endtask : s_erase

   // second write over a written byte shows the built-in erase
   task automatic s_eeprom();
      cmd(8'hC0, 8'h03, 8'hA7, 8'h5A);
      flags("ee_write", 1'b1, 1'b1);
      rd_check("ee_poll", 8'hA0, 8'h03, 8'hA7, 8'hFF);
      wait_idle();
      rd_check("ee_read", 8'hA0, 8'h03, 8'hA7, 8'h5A);
      cmd(8'hC0, 8'h03, 8'hA7, 8'hA5);
      wait_idle();
      rd_check("ee_rewrite", 8'hA0, 8'h03, 8'hA7, 8'hA5);
      rd_check("ee_neighbour", 8'hA0, 8'h03, 8'hA6, 8'hFF);
   endtask : s_eeprom

   // first and last word of page 0x9A, low byte before high; all-ones words skipped
   task automatic s_page();
      cmd(8'h40, 8'h00, 8'h00, 8'h11);
      cmd(8'h48, 8'h00, 8'h00, 8'h22);
      cmd(8'h40, 8'h00, 8'h3F, 8'h33);
      cmd(8'h48, 8'h00, 8'h3F, 8'h44);
      cmd(WRITE_PAGE_B1, 8'h26, 8'h80, 8'h00);
      flags("page_write", 1'b1, 1'b1);
      rd_check("page_poll", 8'h20, 8'h26, 8'h95, 8'hFF);
      wait_idle();
      rd_check("page_w0_lo", 8'h20, 8'h26, 8'h80, 8'h11);
      rd_check("page_w0_hi", 8'h28, 8'h26, 8'h80, 8'h22);
      rd_check("page_w63_lo", 8'h20, 8'h26, 8'hBF, 8'h33);
      rd_check("page_w63_hi", 8'h28, 8'h26, 8'hBF, 8'h44);
      rd_check("page_outside", 8'h20, 8'h26, 8'h7F, 8'hFF);
      rd_check("page_skipped", 8'h28, 8'h26, 8'h95, 8'hFF);
   endtask : s_page

   // reset pin high leaves the mode and shuts the link
   task automatic s_exit();
      prog.set_reset_pin(1'b1, 400);
      flags("exit", 1'b0, 1'b0);
      cmd(8'hC0, 8'h00, 8'h10, 8'h77);
      flags("exit_write", 1'b0, 1'b0);
      prog.set_reset_pin(1'b0, 400);
   endtask : s_exit

   // a slipped bit moves the echo one place left until the reset pin pulses
   task automatic s_resync();
      prog.one_bit(1'b1);
      cmd(PROG_ENABLE_B1, PROG_ENABLE_B2, 8'h00, 8'h00);
      check("slip_echo", echo, 8'h52);
      flags("slip", 1'b0, 1'b0);
      prog.set_reset_pin(1'b1, 200);
      prog.set_reset_pin(1'b0, 200);
      cmd(PROG_ENABLE_B1, PROG_ENABLE_B2, 8'h00, 8'h00);
      check("resync_echo", echo, 8'h53);
      flags("resync", 1'b1, 1'b0);
      rd_check("kept_ee", 8'hA0, 8'h03, 8'hA7, 8'hA5);
      rd_check("ignored_ee", 8'hA0, 8'h00, 8'h10, 8'hFF);
   endtask : s_resync

   task automatic end_of_test();
      if (n_fail == 0 && total_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : end_of_test

   // watchdog, about twice the expected run
   initial begin
      #(60000 * 40);
      n_fail++;
      end_of_test();
   end

   // main sequence
   initial begin
      n_fail = 0;
      total_checks = 0;
      srst = 1'b1;
      repeat (8) @(posedge ref_clk);
      #2 srst = 1'b0;
      wait (prog.link_ready === 1'b1);
      s_not_enabled();
      s_enable();
      s_erase();
      s_eeprom();
      s_page();
      s_exit();
      s_resync();
      end_of_test();
   end
endmodule : tb_top
